/* core/sensor_nvm_pkg.sv */
// constants shared by the sensor configuration access logic
// assumes a 40 MHz system clock and a two-wire bus sampled by that clock
package sensor_nvm_pkg;

	// bus address and command bytes
	localparam logic [6:0] SLAVE_ADDR = 7'h44;
	localparam logic [7:0] CMD_ENTER = 8'ha0;
	localparam logic [7:0] CMD_EXIT = 8'h80;
	localparam logic [7:0] REG_HUM_RD = 8'h06;
	localparam logic [7:0] REG_TEMP_RD = 8'h11;
	localparam logic [7:0] REG_ID_HI = 8'h1e;
	localparam logic [7:0] REG_ID_LO = 8'h1f;
	localparam logic [7:0] REG_HUM_WR = 8'h46;
	localparam logic [7:0] REG_TEMP_WR = 8'h51;

	// resolution field and codes
	localparam int RES_LSB = 10;
	localparam int RES_MSB = 11;
	localparam logic [1:0] RES_8 = 2'h0;
	localparam logic [1:0] RES_10 = 2'h1;
	localparam logic [1:0] RES_12 = 2'h2;
	localparam logic [1:0] RES_14 = 2'h3;
	localparam logic [15:0] RES_REG_RESET = 16'h0c00;

	// read-out status codes
	localparam logic [1:0] STAT_VALID = 2'h0;
	localparam logic [1:0] STAT_STALE = 2'h1;
	localparam logic [7:0] NVM_STATUS = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'hff;

	// transaction shape
	localparam logic [2:0] CMD_BYTES = 3'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// timing, in printed units, and derived cycle counts
	localparam int CLK_MHZ = 40;
	localparam int WIN_MS = 10;
	localparam int ENTRY_US = 120;
	localparam int WRITE_MS = 14;
	localparam int WIN_CYC = WIN_MS * 1000 * CLK_MHZ;
	localparam int ENTRY_CYC = ENTRY_US * CLK_MHZ;
	localparam int WRITE_CYC = WRITE_MS * 1000 * CLK_MHZ;
	localparam int TMR_W = 20;

	// bus slave states
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_AACK, S_WR, S_WACK, S_RD, S_MACK} bus_state_t;

endpackage : sensor_nvm_pkg

/* core/sensor_nvm_config_access.sv */
// two-wire slave giving access to the sensor's non-volatile configuration and measurement read-out
// assumes scl and sda arrive asynchronously; sda is open drain, resolved outside from sda_oe
module sensor_nvm_config_access #(
	parameter int WIN_CYCLES = sensor_nvm_pkg::WIN_CYC,
	parameter int ENTRY_CYCLES = sensor_nvm_pkg::ENTRY_CYC,
	parameter int WRITE_CYCLES = sensor_nvm_pkg::WRITE_CYC,
	parameter logic [31:0] SENSOR_ID = 32'h1234_5678 // arbitrary value
) (
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// two-wire bus pins
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// measurement results from the conversion core
	input wire logic [13:0] hum_raw,
	input wire logic [13:0] temp_raw,
	input wire logic meas_update,
	// configuration and mode status
	output logic [1:0] hum_res,
	output logic [1:0] temp_res,
	output logic prog_mode,
	output logic nvm_ready
);

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [19:0] WIN_LIM = 20'(WIN_CYCLES);
	localparam logic [19:0] ENTRY_LD = 20'(ENTRY_CYCLES);
	localparam logic [19:0] WRITE_LD = 20'(WRITE_CYCLES);

	logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
	sensor_nvm_pkg::bus_state_t state_r, state_nxt;
	logic [2:0] bit_r, bit_nxt, wcnt_r, wcnt_nxt;
	logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, rd_sel_r, rd_sel_nxt;
	logic [23:0] wbuf_r, wbuf_nxt;
	logic [1:0] rbyte_r, rbyte_nxt;
	logic done_r, done_nxt, rw_r, rw_nxt, sda_o_r, sda_o_nxt, sda_oe_r, sda_oe_nxt;
	logic prog_r, prog_nxt, nvm_rd_r, nvm_rd_nxt, stale_r, stale_nxt;
	logic [19:0] tmr_r, tmr_nxt, win_r, win_nxt;
	logic [15:0] hum_reg_r, hum_reg_nxt, temp_reg_r, temp_reg_nxt;
	logic scl_rise, scl_fall, start_det, stop_det, exec, ready, win_open;
	logic [7:0] cmd, txb;
	logic [1:0] tx_idx;
	logic [15:0] rword;

	////////////////////////////////////////////////////////////////////////////////
	// register selected by a read command
	function automatic logic [15:0] read_word(input logic [7:0] sel, input logic [15:0] hum,
			input logic [15:0] temp);
		unique case (sel)
			sensor_nvm_pkg::REG_HUM_RD: read_word = hum;
			sensor_nvm_pkg::REG_TEMP_RD: read_word = temp;
			sensor_nvm_pkg::REG_ID_HI: read_word = SENSOR_ID[31:16];
			default: read_word = SENSOR_ID[15:0];
		endcase
	endfunction : read_word

	// command byte names a readable register
	function automatic logic is_read_reg(input logic [7:0] c);
		is_read_reg = (c == sensor_nvm_pkg::REG_HUM_RD) || (c == sensor_nvm_pkg::REG_TEMP_RD) ||
			(c == sensor_nvm_pkg::REG_ID_HI) || (c == sensor_nvm_pkg::REG_ID_LO);
	endfunction : is_read_reg

	////////////////////////////////////////////////////////////////////////////////
	// bus event detection on the second synchroniser stage and its delayed copy
	assign scl_rise = scl_s2_r & ~scl_d_r;
	assign scl_fall = ~scl_s2_r & scl_d_r;
	assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// command decode and mode qualifiers
	assign cmd = wbuf_r[23:16];
	assign exec = stop_det && !rw_r && (state_r == sensor_nvm_pkg::S_WR) && (wcnt_r == sensor_nvm_pkg::CMD_BYTES);
	assign ready = prog_r && (tmr_r == '0);
	assign win_open = win_r < WIN_LIM;

	// a read always opens with byte 0, whatever count the previous read left behind
	assign tx_idx = (state_r == sensor_nvm_pkg::S_AACK) ? 2'h0 : rbyte_r;
	assign rword = read_word(rd_sel_r, hum_reg_r, temp_reg_r);

	// next byte to send, register read or measurement read-out
	always_comb begin
		if (nvm_rd_r) begin
			unique case (tx_idx)
				2'h0: txb = sensor_nvm_pkg::NVM_STATUS;
				2'h1: txb = rword[15:8];
				2'h2: txb = rword[7:0];
				default: txb = sensor_nvm_pkg::FILL_BYTE;
			endcase
		end else begin
			unique case (tx_idx)
				2'h0: txb = {(stale_r ? sensor_nvm_pkg::STAT_STALE : sensor_nvm_pkg::STAT_VALID), hum_raw[13:8]};
				2'h1: txb = hum_raw[7:0];
				2'h2: txb = temp_raw[13:6];
				default: txb = {temp_raw[5:0], 2'h0};
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state of bus slave, mode and configuration
	always_comb begin
		state_nxt = state_r;
		bit_nxt = bit_r;
		wcnt_nxt = wcnt_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		rd_sel_nxt = rd_sel_r;
		wbuf_nxt = wbuf_r;
		rbyte_nxt = rbyte_r;
		done_nxt = done_r;
		rw_nxt = rw_r;
		sda_o_nxt = sda_o_r;
		sda_oe_nxt = sda_oe_r;
		prog_nxt = prog_r;
		nvm_rd_nxt = nvm_rd_r;
		stale_nxt = stale_r;
		hum_reg_nxt = hum_reg_r;
		temp_reg_nxt = temp_reg_r;
		tmr_nxt = (tmr_r != '0) ? tmr_r - 20'h00001 : tmr_r;
		win_nxt = win_open ? win_r + 20'h00001 : win_r;
		if (start_det) begin
			state_nxt = sensor_nvm_pkg::S_ADDR;
			bit_nxt = '0;
			wcnt_nxt = '0;
			done_nxt = 1'b0;
			sda_oe_nxt = 1'b0;
		end else if (stop_det) begin
			state_nxt = sensor_nvm_pkg::S_IDLE;
			sda_oe_nxt = 1'b0;
			if (exec) begin
				nvm_rd_nxt = 1'b0;
				if (cmd == sensor_nvm_pkg::CMD_ENTER) begin
					if (win_open && !prog_r) begin
						prog_nxt = 1'b1;
						tmr_nxt = ENTRY_LD;
					end
				end else if (cmd == sensor_nvm_pkg::CMD_EXIT) begin
					prog_nxt = 1'b0;
				end else if (ready) begin
					if (is_read_reg(cmd)) begin
						nvm_rd_nxt = 1'b1;
						rd_sel_nxt = cmd;
					end else if (cmd == sensor_nvm_pkg::REG_HUM_WR) begin
						hum_reg_nxt = wbuf_r[15:0];
						tmr_nxt = WRITE_LD;
					end else if (cmd == sensor_nvm_pkg::REG_TEMP_WR) begin
						temp_reg_nxt = wbuf_r[15:0];
						tmr_nxt = WRITE_LD;
					end
				end
			end
		end else if (scl_rise) begin
			unique case (state_r)
				sensor_nvm_pkg::S_ADDR, sensor_nvm_pkg::S_WR: begin
					shift_nxt = {shift_r[6:0], sda_s2_r};
					bit_nxt = bit_r + 3'h1;
					done_nxt = (bit_r == sensor_nvm_pkg::BIT_LAST);
				end
				sensor_nvm_pkg::S_RD: begin
					bit_nxt = bit_r + 3'h1;
					done_nxt = (bit_r == sensor_nvm_pkg::BIT_LAST);
				end
				sensor_nvm_pkg::S_MACK: begin
					if (sda_s2_r) begin
						state_nxt = sensor_nvm_pkg::S_IDLE; // master ends the read
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (state_r)
				sensor_nvm_pkg::S_ADDR: begin
					if (done_r) begin
						done_nxt = 1'b0;
						if (shift_r[7:1] == sensor_nvm_pkg::SLAVE_ADDR) begin
							state_nxt = sensor_nvm_pkg::S_AACK;
							rw_nxt = shift_r[0];
							sda_o_nxt = 1'b0;
							sda_oe_nxt = 1'b1;
						end else begin
							state_nxt = sensor_nvm_pkg::S_IDLE;
						end
					end
				end
				sensor_nvm_pkg::S_WR: begin
					if (done_r) begin
						done_nxt = 1'b0;
						wbuf_nxt = {wbuf_r[15:0], shift_r};
						wcnt_nxt = (wcnt_r > sensor_nvm_pkg::CMD_BYTES) ? wcnt_r : wcnt_r + 3'h1;
						state_nxt = sensor_nvm_pkg::S_WACK;
						sda_o_nxt = 1'b0;
						sda_oe_nxt = 1'b1;
					end
				end
				sensor_nvm_pkg::S_AACK, sensor_nvm_pkg::S_MACK: begin
					if (state_r == sensor_nvm_pkg::S_MACK || rw_r) begin
						if (state_r == sensor_nvm_pkg::S_AACK) begin
							rbyte_nxt = 2'h1;
							stale_nxt = stale_r | ~nvm_rd_r;
						end else begin
							rbyte_nxt = rbyte_r + 2'h1;
						end
						tx_nxt = txb;
						sda_o_nxt = txb[7];
						sda_oe_nxt = 1'b1;
						bit_nxt = '0;
						state_nxt = sensor_nvm_pkg::S_RD;
					end else begin
						sda_oe_nxt = 1'b0;
						bit_nxt = '0;
						state_nxt = sensor_nvm_pkg::S_WR;
					end
				end
				sensor_nvm_pkg::S_WACK: begin
					sda_oe_nxt = 1'b0;
					state_nxt = sensor_nvm_pkg::S_WR;
				end
				sensor_nvm_pkg::S_RD: begin
					if (done_r) begin
						done_nxt = 1'b0;
						sda_oe_nxt = 1'b0;
						state_nxt = sensor_nvm_pkg::S_MACK;
					end else begin
						tx_nxt = {tx_r[6:0], 1'b0};
						sda_o_nxt = tx_r[6];
					end
				end
				default: begin
				end
			endcase
		end
		// fresh measurement makes the read-out valid again
		if (meas_update) begin
			stale_nxt = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers, frozen while clk_en is low
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			{scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r} <= 6'h3f;
			state_r <= sensor_nvm_pkg::S_IDLE;
			bit_r <= '0;
			wcnt_r <= '0;
			shift_r <= '0;
			tx_r <= '0;
			rd_sel_r <= '0;
			wbuf_r <= '0;
			rbyte_r <= '0;
			done_r <= 1'b0;
			rw_r <= 1'b0;
			sda_o_r <= 1'b1;
			sda_oe_r <= 1'b0;
			prog_r <= 1'b0;
			nvm_rd_r <= 1'b0;
			stale_r <= 1'b1;
			tmr_r <= '0;
			win_r <= '0;
			hum_reg_r <= sensor_nvm_pkg::RES_REG_RESET;
			temp_reg_r <= sensor_nvm_pkg::RES_REG_RESET;
		end else if (clk_en) begin
			{scl_s1_r, scl_s2_r, scl_d_r} <= {scl, scl_s1_r, scl_s2_r};
			{sda_s1_r, sda_s2_r, sda_d_r} <= {sda_in, sda_s1_r, sda_s2_r};
			state_r <= state_nxt;
			bit_r <= bit_nxt;
			wcnt_r <= wcnt_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			rd_sel_r <= rd_sel_nxt;
			wbuf_r <= wbuf_nxt;
			rbyte_r <= rbyte_nxt;
			done_r <= done_nxt;
			rw_r <= rw_nxt;
			sda_o_r <= sda_o_nxt;
			sda_oe_r <= sda_oe_nxt;
			prog_r <= prog_nxt;
			nvm_rd_r <= nvm_rd_nxt;
			stale_r <= stale_nxt;
			tmr_r <= tmr_nxt;
			win_r <= win_nxt;
			hum_reg_r <= hum_reg_nxt;
			temp_reg_r <= temp_reg_nxt;
		end
	end

	// outputs
	assign sda_out = sda_o_r;
	assign sda_oe = sda_oe_r;
	assign hum_res = hum_reg_r[sensor_nvm_pkg::RES_MSB:sensor_nvm_pkg::RES_LSB];
	assign temp_res = temp_reg_r[sensor_nvm_pkg::RES_MSB:sensor_nvm_pkg::RES_LSB];
	assign prog_mode = prog_r;
	assign nvm_ready = ready;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_entry_delay;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && cmd == sensor_nvm_pkg::CMD_ENTER && win_open && !prog_r |=> prog_r && !ready && tmr_r == ENTRY_LD;
	endproperty
	a_entry_delay: assert property (p_entry_delay) else $error("entry delay not loaded");

	property p_ignore_early;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && !ready |=> $stable(hum_reg_r) && $stable(temp_reg_r) && !nvm_rd_r;
	endproperty
	a_ignore_early: assert property (p_ignore_early) else $error("access accepted while not ready");

	property p_hum_write;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && ready && cmd == sensor_nvm_pkg::REG_HUM_WR |=> hum_reg_r == $past(wbuf_r[15:0]) && tmr_r == WRITE_LD;
	endproperty
	a_hum_write: assert property (p_hum_write) else $error("humidity write not stored");

	property p_independent;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && ready && cmd == sensor_nvm_pkg::REG_HUM_WR |=> $stable(temp_reg_r);
	endproperty
	a_independent: assert property (p_independent) else $error("temperature setting disturbed");

	property p_temp_read;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && ready && cmd == sensor_nvm_pkg::REG_TEMP_RD |=> nvm_rd_r && read_word(rd_sel_r, hum_reg_r, temp_reg_r) == temp_reg_r;
	endproperty
	a_temp_read: assert property (p_temp_read) else $error("temperature read selects wrong word");

	property p_id_low;
		@(posedge sys_clk) disable iff (!resetn)
		clk_en && exec && ready && cmd == sensor_nvm_pkg::REG_ID_LO |=> read_word(rd_sel_r, hum_reg_r, temp_reg_r) == SENSOR_ID[15:0];
	endproperty
	a_id_low: assert property (p_id_low) else $error("identifier lower half wrong");

	property p_addr_only;
		@(posedge sys_clk) disable iff (!resetn)
		state_r == sensor_nvm_pkg::S_AACK |-> shift_r[7:1] == sensor_nvm_pkg::SLAVE_ADDR && sda_oe_r && !sda_o_r;
	endproperty
	a_addr_only: assert property (p_addr_only) else $error("foreign address acknowledged");

	property p_meas_first;
		@(posedge sys_clk) disable iff (!resetn)
		state_r == sensor_nvm_pkg::S_RD && $past(state_r) == sensor_nvm_pkg::S_AACK && !nvm_rd_r |-> tx_r[5:0] == $past(hum_raw[13:8]);
	endproperty
	a_meas_first: assert property (p_meas_first) else $error("read-out not msb first");

	property p_nvm_high;
		@(posedge sys_clk) disable iff (!resetn)
		state_r == sensor_nvm_pkg::S_RD && $past(state_r) == sensor_nvm_pkg::S_MACK && nvm_rd_r && rbyte_r == 2'h2
			|-> {tx_r, 8'h00} == (read_word(rd_sel_r, hum_reg_r, temp_reg_r) & 16'hff00);
	endproperty
	a_nvm_high: assert property (p_nvm_high) else $error("register high byte not sent after status");

endmodule : sensor_nvm_config_access

/* verif/bus_master_model.sv */
// bus master model that drives the two-wire link toward the sensor block
// assumes a pull-up on sda outside: sda is the resolved wire, sda_low pulls it down
module bus_master_model (
	// alignment clock
	input wire logic sys_clk,
	// two-wire link
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 100ps;

	int lo_extra = 0; // extra low time per bit, a multiple of 25, for a slow master

	// link idles released and high
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one bit: data moves only while scl is low, sampled in mid high phase
	task automatic bit_x(input logic b, output logic s);
		#25 sda_low = !b;
		#(75 + lo_extra) scl = 1'b1;
		#50 s = sda;
		#50 scl = 1'b0;
	endtask : bit_x

	// start after a bus free gap, aligned just after a clock edge
	task automatic start_c();
		@(posedge sys_clk);
		#1002 sda_low = 1'b1;
		#100 scl = 1'b0;
	endtask : start_c

	// stop: sda rises while scl is high
	task automatic stop_c();
		#25 sda_low = 1'b1;
		#75 scl = 1'b1;
		#100 sda_low = 1'b0;
		#100;
	endtask : stop_c

	// byte out, ninth bit returns the slave's acknowledge
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], s);
		end
		bit_x(1'b1, s);
		ack = !s;
	endtask : wr_byte

	// byte in, master acknowledges while more bytes are wanted
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, d[i]);
		end
		bit_x(!more, s);
	endtask : rd_byte

	////////////////////////////////////////////////////////////////////////
	// three written bytes after the address: command then two data bytes
	task automatic send3(input logic [6:0] adr, input logic [7:0] c, input logic [15:0] d, output logic ack);
		logic a0, a1, a2, a3;
		start_c();
		wr_byte({adr, 1'b0}, a0);
		wr_byte(c, a1);
		wr_byte(d[15:8], a2);
		wr_byte(d[7:0], a3);
		stop_c();
		ack = a0 & a1 & a2 & a3;
	endtask : send3

	// read n bytes, most significant first, nack on the last
	task automatic fetch(input int n, output logic [31:0] v);
		logic a;
		logic [7:0] b;
		v = '0;
		start_c();
		wr_byte({sensor_nvm_pkg::SLAVE_ADDR, 1'b1}, a);
		for (int i = 0; i < n; i++) begin
			rd_byte(i < n - 1, b);
			v = {v[23:0], b};
		end
		stop_c();
	endtask : fetch
endmodule : bus_master_model

/* verif/sensor_nvm_config_access_tb.sv */
// self-checking bench for the sensor configuration access block
// assumes the master model drives the link; sda resolved here with a pull-up
module sensor_nvm_config_access_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int WIN_C = 2000;
	localparam int ENT_C = 50;
	localparam int WR_C = 100;
	localparam logic [31:0] ID_VAL = 32'h5a3c_96e1; // arbitrary value

	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic meas_update = 1'b0;
	logic clk_en = 1'b1;
	logic [13:0] hum_raw = 14'h0;
	logic [13:0] temp_raw = 14'h0;
	logic scl, sda_low, sda_out, sda_oe, prog_mode, nvm_ready, ack;
	logic [1:0] hum_res, temp_res;
	logic [31:0] v;
	int bad_count = 0;
	int tests_run = 0;
	wire logic sda = !(sda_low || (sda_oe && !sda_out)); // open drain with pull-up

	// clock
	always #12.5 sys_clk = ~sys_clk;

	// design and far-side master
	sensor_nvm_config_access #(.WIN_CYCLES(WIN_C), .ENTRY_CYCLES(ENT_C), .WRITE_CYCLES(WR_C), .SENSOR_ID(ID_VAL))
		sensor_nvm_config_access_inst (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .scl(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .hum_raw(hum_raw), .temp_raw(temp_raw),
		.meas_update(meas_update), .hum_res(hum_res), .temp_res(temp_res), .prog_mode(prog_mode),
		.nvm_ready(nvm_ready));
	bus_master_model bus_master_model_inst (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////////////
	// comparison, verdict and small helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : cyc

	task automatic cmd(input logic [7:0] c, input logic [15:0] d);
		bus_master_model_inst.send3(sensor_nvm_pkg::SLAVE_ADDR, c, d, ack);
		check(16'(ack), 16'h1, "command acknowledged");
	endtask : cmd

	task automatic regrd(input logic [7:0] a, output logic [15:0] r);
		cmd(a, 16'h0);
		cyc(ENT_C);
		bus_master_model_inst.fetch(3, v);
		check(16'(v[23:16]), 16'(sensor_nvm_pkg::NVM_STATUS), "status byte");
		r = v[15:0];
	endtask : regrd

	task automatic regwr(input logic [7:0] a, input logic [15:0] d);
		cmd(a, d);
		check(16'(nvm_ready), 16'h0, "busy after write");
		cyc(WR_C + 4);
	endtask : regwr

	////////////////////////////////////////////////////////////////////////
	// test sequence
	initial begin
		logic [15:0] r;
		cyc(16);
		resetn = 1'b1;
		check(16'({prog_mode, nvm_ready, sda_oe}), 16'h0, "idle after reset");
		check(16'({hum_res, temp_res}), 16'hf, "default resolutions");
		bus_master_model_inst.send3(7'h45, sensor_nvm_pkg::CMD_ENTER, 16'h0, ack);
		check(16'(ack), 16'h0, "foreign address acknowledged");
		check(16'(prog_mode), 16'h0, "entry via foreign address");
		cmd(sensor_nvm_pkg::REG_HUM_WR, 16'h0);
		check(16'(hum_res), 16'h3, "write outside mode");
		$display("test refusals done");
		cmd(sensor_nvm_pkg::CMD_ENTER, 16'h0);
		check(16'({prog_mode, nvm_ready}), 16'h2, "entry pending");
		cyc(ENT_C - 10);
		check(16'(nvm_ready), 16'h0, "entry still processing");
		clk_en = 1'b0;
		cyc(20);
		check(16'(nvm_ready), 16'h0, "entry timer frozen");
		clk_en = 1'b1;
		cyc(14);
		check(16'(nvm_ready), 16'h1, "entry done");
		regrd(sensor_nvm_pkg::REG_HUM_RD, r);
		check(r, sensor_nvm_pkg::RES_REG_RESET, "humidity register");
		regrd(sensor_nvm_pkg::REG_TEMP_RD, r);
		check(r, sensor_nvm_pkg::RES_REG_RESET, "temperature register");
		$display("test entry done");
		// every resolution code through read-modify-write
		for (int c = 0; c < 4; c++) begin
			regrd(sensor_nvm_pkg::REG_HUM_RD, r);
			r[11:10] = 2'(c);
			regwr(sensor_nvm_pkg::REG_HUM_WR, r);
			check(16'(hum_res), 16'(c), "humidity code");
			check(16'(temp_res), 16'h3, "temperature untouched");
			regrd(sensor_nvm_pkg::REG_HUM_RD, r);
			check(r, {4'h0, 2'(c), 10'h0}, "humidity read back");
		end
		regrd(sensor_nvm_pkg::REG_TEMP_RD, r);
		r[11:10] = sensor_nvm_pkg::RES_10;
		regwr(sensor_nvm_pkg::REG_TEMP_WR, r);
		check(16'({hum_res, temp_res}), 16'hd, "independent resolutions");
		cmd(8'h47, 16'h0);
		cyc(WR_C + 4);
		check(16'({hum_res, temp_res}), 16'hd, "unmapped write");
		$display("test resolution done");
		// identifier halves with a slow master
		bus_master_model_inst.lo_extra = 200;
		regrd(sensor_nvm_pkg::REG_ID_HI, r);
		check(r, ID_VAL[31:16], "identifier upper");
		regrd(sensor_nvm_pkg::REG_ID_LO, r);
		check(r, ID_VAL[15:0], "identifier lower");
		bus_master_model_inst.lo_extra = 0;
		$display("test identifier done");
		cmd(sensor_nvm_pkg::CMD_EXIT, 16'h0);
		check(16'(prog_mode), 16'h0, "programming mode left");
		hum_raw = 14'h2a5c;
		temp_raw = 14'h1b37;
		meas_update = 1'b1;
		cyc(1);
		meas_update = 1'b0;
		bus_master_model_inst.fetch(4, v);
		check(v[31:16], {sensor_nvm_pkg::STAT_VALID, hum_raw}, "humidity word");
		check(v[15:0] & 16'hfffc, {temp_raw, 2'h0}, "temperature word");
		check(16'(int'(v[29:16]) * 100 / 16383), 16'h0042, "humidity percent");
		check(16'(int'(v[15:2]) * 165 / 16383 - 40), 16'h001e, "temperature celsius");
		bus_master_model_inst.fetch(2, v);
		check(v[15:0], {sensor_nvm_pkg::STAT_STALE, hum_raw}, "stale humidity word");
		$display("test readout done");
		// second reset, then an entry after the power-up window
		resetn = 1'b0;
		cyc(2);
		resetn = 1'b1;
		check(16'({hum_res, temp_res}), 16'hf, "resolutions after reset");
		cyc(WIN_C);
		cmd(sensor_nvm_pkg::CMD_ENTER, 16'h0);
		cyc(ENT_C + 10);
		check(16'({prog_mode, nvm_ready}), 16'h0, "late entry");
		$display("test window done");
		conclude();
	end

	// watchdog against a hung link
	initial begin
		#2000000;
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		conclude();
	end
endmodule : sensor_nvm_config_access_tb
